// *** core/sdt_pkg.sv ***
package sdt_pkg;

  // Instance counts and widths
  localparam int unsigned NUM_TIMERS  = 3;
  localparam int unsigned NUM_PRESC   = 2;
  localparam int unsigned NUM_CH      = 4;
  localparam int unsigned NUM_TICK    = 4;
  localparam int unsigned CNT_W       = 16;

  // Register byte offsets
  localparam logic [7:0] OFS_T0_CFG    = 8'h00;
  localparam logic [7:0] OFS_T0_TARGET = 8'h04;
  localparam logic [7:0] OFS_T0_COUNT  = 8'h08;
  localparam logic [7:0] OFS_T_STRIDE  = 8'h0c;
  localparam logic [7:0] OFS_T2_CFG    = 8'h18;
  localparam logic [7:0] OFS_T2_TARGET = 8'h1c;
  localparam logic [7:0] OFS_T2_COUNT  = 8'h20;
  localparam logic [7:0] OFS_CH_CFG    = 8'h24;
  localparam logic [7:0] OFS_CH_VAL    = 8'h34;
  localparam logic [7:0] OFS_CH_STRIDE = 8'h04;
  localparam logic [7:0] OFS_STATUS    = 8'h44;

  // Timer 0/1 configuration fields
  localparam int unsigned T_EN      = 0;
  localparam int unsigned T_PER     = 1;
  localparam int unsigned T_TICK    = 2;
  localparam int unsigned T_SEL_LSB = 3;
  localparam int unsigned T_EXP_LSB = 8;
  localparam int unsigned T_CFG_W   = 12;

  // Timer 2 configuration fields
  localparam int unsigned T2_EN      = 0;
  localparam int unsigned T2_CLK_LSB = 1;
  localparam int unsigned T2_PER     = 3;
  localparam int unsigned T2_CFG_W   = 4;

  // Timer 2 clock choices
  localparam logic [1:0] CLK_24M = 2'h0;
  localparam logic [1:0] CLK_2M  = 2'h1;
  localparam logic [1:0] CLK_32K = 2'h2;

  // Channel configuration fields
  localparam int unsigned CH_CAP      = 0;
  localparam int unsigned CH_PER      = 1;
  localparam int unsigned CH_ARM      = 2;
  localparam int unsigned CH_EDGE_LSB = 3;
  localparam int unsigned CH_PWM      = 5;
  localparam int unsigned CH_CFG_W    = 6;

  // Status register fields
  localparam int unsigned ST_T2     = 2;
  localparam int unsigned ST_CH_LSB = 3;
  localparam int unsigned ST_W      = 7;

  // Reset values
  localparam logic [CNT_W-1:0] TARGET_RST = 16'hffff;

  // Timer 0/1 state
  typedef struct packed {
    logic [T_CFG_W-1:0] cfg;
    logic [CNT_W-1:0]   target;
    logic [CNT_W-1:0]   cnt;
    logic [CNT_W-1:0]   presc;
  } sdt_presc_timer_t;

  // Capture/compare channel state
  typedef struct packed {
    logic [CH_CFG_W-1:0] cfg;
    logic [CNT_W-1:0]    val;
    logic                wave;
  } sdt_chan_t;

  // Whole block state
  typedef struct packed {
    sdt_presc_timer_t [NUM_PRESC-1:0] pt;
    logic [T2_CFG_W-1:0]              t2_cfg;
    logic [CNT_W-1:0]                 t2_target;
    logic [CNT_W-1:0]                 t2_cnt;
    sdt_chan_t [NUM_CH-1:0]           ch;
    logic [ST_W-1:0]                  status;
    logic [NUM_TICK+NUM_CH-1:0]       s1;
    logic [NUM_TICK+NUM_CH-1:0]       s2;
    logic [NUM_TICK+NUM_CH-1:0]       s3;
    logic [NUM_TIMERS-1:0]            t_evt;
    logic [NUM_CH-1:0]                ch_evt;
    logic [31:0]                      prdata;
    logic                             pready;
    logic                             pslverr;
  } sdt_state_t;

endpackage : sdt_pkg

// *** core/sdt_timer_set.sv ***
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Three independent timers exist, numbered zero, one and two.
// - Timers zero and one: 16-bit counter after a power-of-two prescaler.
// - Timers zero and one advance on the clock or each selected tick edge.
// - Timers zero and one run one-shot (stop) or periodic (reload, continue).
// - Timer two: 16-bit, clocked by 24 MHz, 2 MHz or 32 kHz, one-shot or periodic.
// - Timer two has four channels, capture or compare, one-shot or periodic.
// - Timer two emits trigger pulses and drives PWM or waveform outputs.
module sdt_timer_set (
  // Clock and reset
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  // APB slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [7:0]                   paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  // Tick sources and capture pins from outside the clock domain
  input  wire logic [sdt_pkg::NUM_TICK-1:0] tick_src,
  input  wire logic [sdt_pkg::NUM_CH-1:0]   cap_in,
  // Timer two clock strobes, one pclk wide: 24 MHz, 2 MHz, 32 kHz
  input  wire logic [2:0]                   t2_clk_tick,
  // Event pulses and waveform outputs
  output logic [sdt_pkg::NUM_TIMERS-1:0]    timer_evt,
  output logic [sdt_pkg::NUM_CH-1:0]        chan_evt,
  output logic [sdt_pkg::NUM_CH-1:0]        wave_out
);

  sdt_pkg::sdt_state_t state_reg;
  sdt_pkg::sdt_state_t state_next;

  // Outputs straight from the state flops
  assign prdata    = state_reg.prdata;
  assign pready    = state_reg.pready;
  assign pslverr   = state_reg.pslverr;
  assign timer_evt = state_reg.t_evt;
  assign chan_evt  = state_reg.ch_evt;
  generate
    for (genvar g = 0; g < sdt_pkg::NUM_CH; g++) begin : g_wave
      assign wave_out[g] = state_reg.ch[g].wave;
    end
  endgenerate

  // Next-state logic for bus, timers and channels
  always_comb begin
    logic [sdt_pkg::NUM_TICK+sdt_pkg::NUM_CH-1:0] any_edge;
    logic [sdt_pkg::NUM_TICK+sdt_pkg::NUM_CH-1:0] rise;
    logic [sdt_pkg::NUM_TICK+sdt_pkg::NUM_CH-1:0] fall;
    logic [sdt_pkg::ST_W-1:0]  st_set;
    logic [sdt_pkg::ST_W-1:0]  st_clr;
    logic [sdt_pkg::CNT_W-1:0] mask;
    logic [sdt_pkg::CNT_W-1:0] cnt2;
    logic [1:0]                esel;
    logic [1:0]                csel;
    logic                      src;
    logic                      adv2;
    logic                      wr;
    logic                      hit;
    logic                      fire;
    logic [31:0]               rd;
    state_next = state_reg;
    any_edge   = state_reg.s2 ^ state_reg.s3;
    rise       = state_reg.s2 & ~state_reg.s3;
    fall       = ~state_reg.s2 & state_reg.s3;
    st_set     = '0;
    st_clr     = '0;
    mask       = '0;
    cnt2       = state_reg.t2_cnt;
    esel       = '0;
    csel       = '0;
    src        = 1'b0;
    adv2       = 1'b0;
    wr         = 1'b0;
    hit        = 1'b0;
    fire       = 1'b0;
    rd         = '0;
    state_next.t_evt   = '0;
    state_next.ch_evt  = '0;
    state_next.pready  = 1'b0;
    state_next.pslverr = 1'b0;

    // Three-stage synchronisers for outside pins
    state_next.s1 = {cap_in, tick_src};
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;

    // Prescaled timers zero and one
    for (int i = 0; i < sdt_pkg::NUM_PRESC; i++) begin
      if (state_reg.pt[i].cfg[sdt_pkg::T_TICK]) begin
        src = any_edge[state_reg.pt[i].cfg[sdt_pkg::T_SEL_LSB +: 2]];
      end else begin
        src = 1'b1;
      end
      mask = sdt_pkg::CNT_W'((17'h1 <<
             state_reg.pt[i].cfg[sdt_pkg::T_EXP_LSB +: 4]) - 17'h1);
      if (state_reg.pt[i].cfg[sdt_pkg::T_EN] && src) begin
        if ((state_reg.pt[i].presc & mask) == mask) begin
          state_next.pt[i].presc = '0;
          if (state_reg.pt[i].cnt == state_reg.pt[i].target) begin
            state_next.t_evt[i] = 1'b1;
            st_set[i]           = 1'b1;
            state_next.pt[i].cnt = '0;
            if (!state_reg.pt[i].cfg[sdt_pkg::T_PER]) begin
              state_next.pt[i].cfg[sdt_pkg::T_EN] = 1'b0;
            end
          end else begin
            state_next.pt[i].cnt = state_reg.pt[i].cnt + 16'h1;
          end
        end else begin
          state_next.pt[i].presc = state_reg.pt[i].presc + 16'h1;
        end
      end
    end

    // Timer two counter on the selected clock strobe
    csel = state_reg.t2_cfg[sdt_pkg::T2_CLK_LSB +: 2];
    unique case (csel)
      sdt_pkg::CLK_24M: adv2 = t2_clk_tick[0];
      sdt_pkg::CLK_2M:  adv2 = t2_clk_tick[1];
      sdt_pkg::CLK_32K: adv2 = t2_clk_tick[2];
      default:          adv2 = 1'b0;
    endcase
    adv2 = adv2 && state_reg.t2_cfg[sdt_pkg::T2_EN];
    if (adv2) begin
      if (state_reg.t2_cnt == state_reg.t2_target) begin
        cnt2                                = '0;
        state_next.t_evt[sdt_pkg::ST_T2]    = 1'b1;
        st_set[sdt_pkg::ST_T2]              = 1'b1;
        if (!state_reg.t2_cfg[sdt_pkg::T2_PER]) begin
          state_next.t2_cfg[sdt_pkg::T2_EN] = 1'b0;
        end
      end else begin
        cnt2 = state_reg.t2_cnt + 16'h1;
      end
      state_next.t2_cnt = cnt2;
    end

    // Capture/compare channels of timer two
    for (int c = 0; c < sdt_pkg::NUM_CH; c++) begin
      esel = state_reg.ch[c].cfg[sdt_pkg::CH_EDGE_LSB +: 2];
      fire = 1'b0;
      if (state_reg.ch[c].cfg[sdt_pkg::CH_ARM]) begin
        if (state_reg.ch[c].cfg[sdt_pkg::CH_CAP]) begin
          fire = (esel[0] && rise[sdt_pkg::NUM_TICK + c]) ||
                 (esel[1] && fall[sdt_pkg::NUM_TICK + c]);
          if (fire) begin
            state_next.ch[c].val = state_reg.t2_cnt;
          end
        end else begin
          fire = adv2 && (cnt2 == state_reg.ch[c].val);
        end
      end
      if (state_reg.ch[c].cfg[sdt_pkg::CH_PWM]) begin
        if (adv2 && cnt2 == '0) begin
          state_next.ch[c].wave = 1'b1;
        end
        if (fire) begin
          state_next.ch[c].wave = 1'b0;
        end
      end else if (fire) begin
        state_next.ch[c].wave = ~state_reg.ch[c].wave;
      end
      if (fire) begin
        state_next.ch_evt[c]           = 1'b1;
        st_set[sdt_pkg::ST_CH_LSB + c] = 1'b1;
        if (!state_reg.ch[c].cfg[sdt_pkg::CH_PER]) begin
          state_next.ch[c].cfg[sdt_pkg::CH_ARM] = 1'b0;
        end
      end
    end

    // Register decode, shared by read and write
    for (int i = 0; i < sdt_pkg::NUM_PRESC; i++) begin
      if (paddr == 8'(sdt_pkg::OFS_T0_CFG + i * sdt_pkg::OFS_T_STRIDE)) begin
        hit = 1'b1;
        rd  = 32'(state_reg.pt[i].cfg);
      end
      if (paddr == 8'(sdt_pkg::OFS_T0_TARGET + i * sdt_pkg::OFS_T_STRIDE))
      begin
        hit = 1'b1;
        rd  = 32'(state_reg.pt[i].target);
      end
      if (paddr == 8'(sdt_pkg::OFS_T0_COUNT + i * sdt_pkg::OFS_T_STRIDE)) begin
        hit = 1'b1;
        rd  = 32'(state_reg.pt[i].cnt);
      end
    end
    for (int c = 0; c < sdt_pkg::NUM_CH; c++) begin
      if (paddr == 8'(sdt_pkg::OFS_CH_CFG + c * sdt_pkg::OFS_CH_STRIDE)) begin
        hit = 1'b1;
        rd  = 32'(state_reg.ch[c].cfg);
      end
      if (paddr == 8'(sdt_pkg::OFS_CH_VAL + c * sdt_pkg::OFS_CH_STRIDE)) begin
        hit = 1'b1;
        rd  = 32'(state_reg.ch[c].val);
      end
    end
    if (paddr == sdt_pkg::OFS_T2_CFG) begin
      hit = 1'b1;
      rd  = 32'(state_reg.t2_cfg);
    end
    if (paddr == sdt_pkg::OFS_T2_TARGET) begin
      hit = 1'b1;
      rd  = 32'(state_reg.t2_target);
    end
    if (paddr == sdt_pkg::OFS_T2_COUNT) begin
      hit = 1'b1;
      rd  = 32'(state_reg.t2_cnt);
    end
    if (paddr == sdt_pkg::OFS_STATUS) begin
      hit = 1'b1;
      rd  = 32'(state_reg.status);
    end

    // APB: one wait state, answer registered, write on the ready edge
    if (psel && penable && !state_reg.pready) begin
      state_next.pready  = 1'b1;
      state_next.pslverr = !hit;
      state_next.prdata  = pwrite ? 32'h0 : rd;
    end
    wr = psel && penable && state_reg.pready && pwrite && hit;
    if (wr) begin
      for (int i = 0; i < sdt_pkg::NUM_PRESC; i++) begin
        if (paddr == 8'(sdt_pkg::OFS_T0_CFG + i * sdt_pkg::OFS_T_STRIDE)) begin
          state_next.pt[i].cfg   = pwdata[sdt_pkg::T_CFG_W-1:0];
          state_next.pt[i].cnt   = '0;
          state_next.pt[i].presc = '0;
        end
        if (paddr == 8'(sdt_pkg::OFS_T0_TARGET + i * sdt_pkg::OFS_T_STRIDE))
        begin
          state_next.pt[i].target = pwdata[sdt_pkg::CNT_W-1:0];
        end
      end
      for (int c = 0; c < sdt_pkg::NUM_CH; c++) begin
        if (paddr == 8'(sdt_pkg::OFS_CH_CFG + c * sdt_pkg::OFS_CH_STRIDE))
        begin
          state_next.ch[c].cfg = pwdata[sdt_pkg::CH_CFG_W-1:0];
        end
        if (paddr == 8'(sdt_pkg::OFS_CH_VAL + c * sdt_pkg::OFS_CH_STRIDE))
        begin
          state_next.ch[c].val = pwdata[sdt_pkg::CNT_W-1:0];
        end
      end
      if (paddr == sdt_pkg::OFS_T2_CFG) begin
        state_next.t2_cfg = pwdata[sdt_pkg::T2_CFG_W-1:0];
        state_next.t2_cnt = '0;
      end
      if (paddr == sdt_pkg::OFS_T2_TARGET) begin
        state_next.t2_target = pwdata[sdt_pkg::CNT_W-1:0];
      end
      if (paddr == sdt_pkg::OFS_STATUS) begin
        st_clr = pwdata[sdt_pkg::ST_W-1:0];
      end
    end

    // Sticky event flags: a new event wins over a clear
    state_next.status = (state_reg.status & ~st_clr) | st_set;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg           <= '0;
      state_reg.pt[0].target <= sdt_pkg::TARGET_RST;
      state_reg.pt[1].target <= sdt_pkg::TARGET_RST;
      state_reg.t2_target <= sdt_pkg::TARGET_RST;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule : sdt_timer_set

`default_nettype wire

// *** tb/sdt_far_end.sv ***
`timescale 1ns/1ps
`default_nettype none
module sdt_far_end (
  // Clock and trigger inputs
  input wire logic       pclk,
  input wire logic [2:0] timer_evt,
  input wire logic [3:0] chan_evt
);
  int         cnt [7];
  logic [6:0] evts;
  // All trigger lines side by side
  assign evts = {chan_evt, timer_evt};
  // Consume each trigger pulse as one event
  always @(posedge pclk) begin
    for (int i = 0; i < 7; i++) begin
      if (evts[i] === 1'b1) cnt[i]++;
    end
  end
endmodule : sdt_far_end
`default_nettype wire

// *** tb/sdt_timer_set_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module sdt_timer_set_asserts (
  // Clock, reset and bus
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Timer side
  input wire logic [2:0]  t2_clk_tick,
  input wire logic [2:0]  timer_evt,
  input wire logic [3:0]  chan_evt
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic bad;
  // Pending access and unmapped address
  assign acc = psel && penable && !pready;
  assign bad = paddr > 8'h44 || paddr[1:0] != 2'h0;
  AST_PREADY_ONE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_ANSWER: assert property (acc |=> pready)
    else $error("access not answered");
  AST_NO_STRAY: assert property (pready |-> $past(psel && penable))
    else $error("pready without request");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_UNMAPPED: assert property (acc && bad |=> pslverr)
    else $error("unmapped access not refused");
  AST_MAPPED: assert property (acc && !bad |=> !pslverr)
    else $error("mapped access refused");
  AST_ERR_ZERO: assert property (pslverr |-> prdata == 32'h0)
    else $error("refused read returns data");
  AST_T2_STROBE: assert property (
    timer_evt[2] |-> $past(t2_clk_tick) != 3'h0 ||
      $past(t2_clk_tick, 2) != 3'h0)
    else $error("timer two event without clock strobe");
  // Main scenarios
  cover property (timer_evt[0]);
  cover property (chan_evt[1]);
  cover property (acc && bad);
endmodule : sdt_timer_set_asserts
`default_nettype wire

// *** tb/test_sensor_domain_timer_set.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_sensor_domain_timer_set;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'd51669;
  logic        pready, pslverr, err;
  logic [3:0]  tick_src = 4'h0, cap_in = 4'h0, chan_evt, wave_out, w0;
  logic [2:0]  t2_clk_tick = 3'h0, timer_evt;
  int          n_errors = 0, check_count = 0, div = 0, t, v, c0, lat;
  logic [6:0]  evts;
  always #50 pclk = ~pclk;
  sdt_timer_set sdt_timer_set_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tick_src(tick_src), .cap_in(cap_in), .t2_clk_tick(t2_clk_tick),
    .timer_evt(timer_evt), .chan_evt(chan_evt), .wave_out(wave_out));
  sdt_far_end sdt_far_end_i (.pclk(pclk), .timer_evt(timer_evt),
    .chan_evt(chan_evt));
  // All trigger lines side by side
  assign evts = {chan_evt, timer_evt};
  // Rate strobes: every cycle, every 5th, every 305th
  always @(posedge pclk) begin
    div <= (div == 304) ? 0 : div + 1;
    t2_clk_tick <= {div == 0, div % 5 == 0, 1'b1};
  end
  function automatic int xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return int'(seed[7:0]);
  endfunction : xs
  function automatic int cnt(input int i);
    return sdt_far_end_i.cnt[i];
  endfunction : cnt
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
    if (pready !== 1'b1) n_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input logic ee);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
    chk({31'h0, err}, {31'h0, ee});
  endtask : rdc
  // Wait for event line i, then expect e events in k periods of p cycles
  task automatic win(input int i, input int k, input int p, input int e);
    int n;
    n = 0;
    do @(posedge pclk); while (evts[i] !== 1'b1 && ++n < 4000);
    if (evts[i] !== 1'b1) n_errors++;
    lat = n;
    w0 = wave_out;
    // One edge later the partner has surely counted this event
    @(posedge pclk);
    c0 = cnt(i);
    repeat (k * p) @(posedge pclk);
    chk(32'(cnt(i) - c0), 32'(e));
  endtask : win
  task automatic results();
    if (n_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    results();
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    // Reset values and refused places
    rdc(8'h04, 32'hffff, 0);
    rdc(8'h1c, 32'hffff, 0);
    rdc(8'h14, 32'h0, 0);
    rdc(8'h44, 32'h0, 0);
    rdc(8'h48, 32'h0, 1);
    rdc(8'h02, 32'h0, 1);
    // One-shot, prescale 2, stops after one period
    wr(8'h04, 32'h3);
    wr(8'h00, 32'h101);
    win(0, 5, 8, 0);
    chk(32'(lat), 32'd8);
    rdc(8'h00, 32'h100, 0);
    // Periodic, prescale 4, random target
    t = 2 + xs() % 8;
    wr(8'h10, 32'(t));
    wr(8'h0c, 32'h203);
    win(1, 3, (t + 1) * 4, 3);
    chk(32'(lat), 32'((t + 1) * 4));
    // Tick mode on source 1, both edges count
    wr(8'h04, 32'h2);
    wr(8'h00, 32'h0f);
    c0 = cnt(0);
    repeat (6) begin
      repeat (8) @(posedge pclk);
      tick_src <= tick_src ^ 4'hb;
    end
    repeat (8) @(posedge pclk);
    chk(32'(cnt(0) - c0), 32'h2);
    // Timer two at 2 MHz, compare channel toggles wave
    v = 1 + xs() % 8;
    wr(8'h34, 32'(v));
    wr(8'h24, 32'h06);
    wr(8'h1c, 32'h9);
    wr(8'h18, 32'h0b);
    win(2, 3, 50, 3);
    win(3, 3, 50, 3);
    chk({31'h0, wave_out[0]}, {31'h0, ~w0[0]});
    // PWM on channel two: high from wrap, low from match
    wr(8'h3c, 32'h5);
    wr(8'h2c, 32'h26);
    win(5, 0, 0, 0);
    win(2, 0, 0, 0);
    chk({31'h0, w0[2]}, 32'h1);
    win(5, 0, 0, 0);
    chk({31'h0, w0[2]}, 32'h0);
    // One-shot capture on channel one, falling edge only
    wr(8'h28, 32'h15);
    c0 = cnt(4);
    cap_in[1] <= 1;
    repeat (10) @(posedge pclk);
    cap_in[1] <= 0;
    repeat (10) @(posedge pclk);
    cap_in[1] <= 1;
    repeat (10) @(posedge pclk);
    chk(32'(cnt(4) - c0), 32'h1);
    rdc(8'h28, 32'h11, 0);
    apb(1'b0, 8'h38, 32'h0);
    chk({31'h0, rd < 32'd10}, 32'h1);
    // Timer two at 24 MHz, then at 32 kHz with target zero
    wr(8'h18, 32'h09);
    win(2, 3, 10, 3);
    wr(8'h1c, 32'h0);
    wr(8'h18, 32'h0d);
    win(2, 2, 305, 2);
    // Sticky status, write one to clear
    rdc(8'h44, 32'h3f, 0);
    wr(8'h00, 32'h0);
    wr(8'h0c, 32'h0);
    wr(8'h18, 32'h0);
    wr(8'h24, 32'h0);
    wr(8'h44, 32'h7f);
    rdc(8'h44, 32'h0, 0);
    // Second reset mid-run
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    rdc(8'h04, 32'hffff, 0);
    rdc(8'h2c, 32'h0, 0);
    results();
  end
endmodule : test_sensor_domain_timer_set
bind sdt_timer_set sdt_timer_set_asserts sdt_timer_set_asserts_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .t2_clk_tick(t2_clk_tick), .timer_evt(timer_evt), .chan_evt(chan_evt));
`default_nettype wire
